//--- hw/blc_pkg.sv
// Package of offsets, fields and reset values for the backlight config bank
package blc_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_LOCKOUT_PWM  = 8'ha3;
    localparam logic [7:0] OFS_RES_FAULT_HR = 8'ha4;
    // ------------------------------------------------------------
    // Field positions, lockout_and_pwm_mode_config
    // ------------------------------------------------------------
    localparam int LOCKOUT_LSB   = 6;
    localparam int PHASE_BIT     = 5;
    localparam int FREQ_LSB      = 0;
    // ------------------------------------------------------------
    // Field positions, resolution_fault_headroom_config
    // ------------------------------------------------------------
    localparam int RESOL_LSB     = 6;
    localparam int CURRES_BIT    = 5;
    localparam int FAULT_LSB     = 3;
    localparam int HEADROOM_LSB  = 0;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_LOCKOUT_PWM  = 8'h00;
    localparam logic [7:0] RST_RES_FAULT_HR = 8'h00;
    // ------------------------------------------------------------
    // Decoded levels in millivolts
    // ------------------------------------------------------------
    localparam logic [12:0] HEADROOM_STEP_MV = 13'h007d;
    localparam logic [12:0] FAULT_BASE_MV    = 13'h08fc;
    localparam logic [12:0] FAULT_STEP_MV    = 13'h03e8;
endpackage

//--- hw/blc_bank.sv
// Two configuration registers with decoded setting outputs
// Functional notes
// RULE1 - Phase-shift bit set selects shifted PWM
// RULE2 - Phase-shift bit clear selects normal PWM
// RULE3 - Frequency code is 5-bit RW field
// RULE4 - Current-resistor bit picks external resistor source
// RULE5 - Fault threshold codes 2.3V to 5.3V
// RULE6 - Headroom 125 mV steps, 125 to 1000
// RULE7 - Adaptive boost regulates to Vf plus headroom
// RULE8 - Lockout code 00 off, else 2.7/6/9V
`timescale 1ns/1ps
module blc_bank (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    // Register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    // Decoded settings
    output logic      [1:0]  input_lockout_level_o,
    output logic             lockout_enable_o,
    output logic             phase_shift_dimming_enable_o,
    output logic      [4:0]  output_frequency_code_o,
    output logic      [1:0]  pwm_resolution_o,
    output logic             current_resistor_enable_o,
    output logic      [1:0]  string_fault_threshold_o,
    output logic      [12:0] fault_level_mv_o,
    output logic      [2:0]  sink_headroom_select_o,
    output logic      [12:0] headroom_mv_o
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  cfg_a;
        logic [7:0]  cfg_b;
        logic [7:0]  rdata;
        logic [12:0] fault_mv;
        logic [12:0] head_mv;
        logic        lock_en;
    } blc_state_t;

    blc_state_t st_ff;
    blc_state_t nxt_st;

    // Headroom above saturation; adaptive boost adds this to max Vf
    function automatic logic [12:0] head_mv(input logic [2:0] c);
        head_mv = blc_pkg::HEADROOM_STEP_MV * ({10'h000, c} + 13'h0001);
    endfunction

    function automatic logic [12:0] fault_mv(input logic [1:0] c);
        fault_mv = blc_pkg::FAULT_BASE_MV
                 + blc_pkg::FAULT_STEP_MV * {11'h000, c};
    endfunction

    always_comb begin
        nxt_st       = st_ff;
        nxt_st.rdata = 8'h00;
        if (wr_i && addr_i == blc_pkg::OFS_LOCKOUT_PWM) begin
            nxt_st.cfg_a = wdata_i; // RULE1 RULE2 RULE3 RULE8
        end
        if (wr_i && addr_i == blc_pkg::OFS_RES_FAULT_HR) begin
            nxt_st.cfg_b = wdata_i; // RULE4 RULE5 RULE6
        end
        // Unmapped reads return zero
        if (rd_i) begin
            unique case (addr_i)
                blc_pkg::OFS_LOCKOUT_PWM:  nxt_st.rdata = st_ff.cfg_a;
                blc_pkg::OFS_RES_FAULT_HR: nxt_st.rdata = st_ff.cfg_b;
                default:                   nxt_st.rdata = 8'h00;
            endcase
        end
        nxt_st.fault_mv = fault_mv(nxt_st.cfg_b[blc_pkg::FAULT_LSB +: 2]);
        nxt_st.head_mv  = head_mv(nxt_st.cfg_b[blc_pkg::HEADROOM_LSB +: 3]); // RULE7
        nxt_st.lock_en  = |nxt_st.cfg_a[blc_pkg::LOCKOUT_LSB +: 2]; // RULE8
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st_ff          <= '0;
            st_ff.cfg_a    <= blc_pkg::RST_LOCKOUT_PWM;
            st_ff.cfg_b    <= blc_pkg::RST_RES_FAULT_HR;
            st_ff.fault_mv <= blc_pkg::FAULT_BASE_MV;
            st_ff.head_mv  <= blc_pkg::HEADROOM_STEP_MV;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from the state flops
    // ------------------------------------------------------------
    assign rdata_o                 = st_ff.rdata;
    assign input_lockout_level_o   = st_ff.cfg_a[blc_pkg::LOCKOUT_LSB +: 2];
    assign lockout_enable_o        = st_ff.lock_en;
    assign phase_shift_dimming_enable_o = st_ff.cfg_a[blc_pkg::PHASE_BIT];
    assign output_frequency_code_o = st_ff.cfg_a[blc_pkg::FREQ_LSB +: 5];
    assign pwm_resolution_o        = st_ff.cfg_b[blc_pkg::RESOL_LSB +: 2];
    assign current_resistor_enable_o = st_ff.cfg_b[blc_pkg::CURRES_BIT];
    assign string_fault_threshold_o = st_ff.cfg_b[blc_pkg::FAULT_LSB +: 2];
    assign fault_level_mv_o        = st_ff.fault_mv;
    assign sink_headroom_select_o  = st_ff.cfg_b[blc_pkg::HEADROOM_LSB +: 3];
    assign headroom_mv_o           = st_ff.head_mv;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence wr_a_s;
        wr_i && addr_i == blc_pkg::OFS_LOCKOUT_PWM;
    endsequence
    sequence wr_b_s;
        wr_i && addr_i == blc_pkg::OFS_RES_FAULT_HR;
    endsequence

    phase_on_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE1
        wr_a_s ##1 1'b1 |-> phase_shift_dimming_enable_o == $past(wdata_i[5]))
        else $error("phase enable not written");
    phase_off_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE2
        (wr_a_s and (!wdata_i[5])) |=> !phase_shift_dimming_enable_o)
        else $error("phase enable not cleared");
    freq_rw_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE3
        wr_a_s ##1 (rd_i && addr_i == blc_pkg::OFS_LOCKOUT_PWM && !wr_i)
        |=> rdata_o[4:0] == $past(wdata_i[4:0], 2))
        else $error("frequency readback wrong");
    cur_res_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE4
        wr_b_s |=> current_resistor_enable_o == $past(wdata_i[5]))
        else $error("current resistor bit wrong");
    fault_lvl_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE5
        string_fault_threshold_o == 2'h3 |-> fault_level_mv_o == 13'h14b4)
        else $error("fault level wrong");
    head_lvl_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE6
        sink_headroom_select_o == 3'h7 |-> headroom_mv_o == 13'h03e8)
        else $error("headroom level wrong");
    head_step_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE7
        headroom_mv_o == 13'h007d * ({10'h000, sink_headroom_select_o}
                                     + 13'h0001))
        else $error("headroom not tracking select");
    lockout_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE8
        lockout_enable_o == (input_lockout_level_o != 2'h0))
        else $error("lockout enable wrong");
endmodule // blc_bank

//--- dv/test_blc_bank.sv
// Self-checking testbench for the backlight configuration bank
`timescale 1ns/1ps
module test_blc_bank;
    logic        clk_i   = 1'b0;
    logic        reset_i = 1'b1;
    logic [7:0]  addr_i  = 8'h00;
    logic [7:0]  wdata_i = 8'h00;
    logic        wr_i    = 1'b0;
    logic        rd_i    = 1'b0;
    logic [7:0]  rdata_o;
    logic [1:0]  lvl_o, res_o, thr_o;
    logic        lo_en_o, ph_o, cur_o;
    logic [4:0]  freq_o;
    logic [2:0]  hr_o;
    logic [12:0] flt_mv_o, hr_mv_o;
    int          bad_count   = 0;
    int          checks_done = 0;
    blc_bank blc_bank_inst (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .input_lockout_level_o(lvl_o), .lockout_enable_o(lo_en_o),
        .phase_shift_dimming_enable_o(ph_o), .output_frequency_code_o(freq_o),
        .pwm_resolution_o(res_o), .current_resistor_enable_o(cur_o),
        .string_fault_threshold_o(thr_o), .fault_level_mv_o(flt_mv_o),
        .sink_headroom_select_o(hr_o), .headroom_mv_o(hr_mv_o));
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    task automatic chk(string n, logic [12:0] seen, logic [12:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk_i);
        {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(posedge clk_i);
        {rd_i, addr_i} <= {1'b1, a};
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk("rdata", 13'(rdata_o), 13'(exp));
        @(posedge clk_i);
        #1 chk("rdata_idle", 13'(rdata_o), 13'h0000);
    endtask
    // Write then read on the very next cycle
    task automatic wr_rd(logic [7:0] a, logic [7:0] d);
        @(posedge clk_i);
        {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
        @(posedge clk_i);
        {wr_i, rd_i} <= {1'b0, 1'b1};
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk("wr_rd", 13'(rdata_o), 13'(d));
    endtask
    task automatic t_reset();
        chk("a3_fields", {lvl_o, lo_en_o, ph_o, freq_o}, 13'h0000);
        chk("a4_fields", {res_o, cur_o, thr_o, hr_o}, 13'h0000);
        chk("fault_mv", flt_mv_o, 13'h08fc);
        chk("head_mv", hr_mv_o, 13'h007d);
    endtask
    task automatic t_a3();
        logic [7:0] d;
        for (int i = 0; i < 4; i++) begin
            d = {i[1:0], i[0], 5'(8'h1f - 8'(i * 9))};
            wr(blc_pkg::OFS_LOCKOUT_PWM, d);
            chk("lockout", 13'(lvl_o), 13'(d[7:6]));
            chk("lockout_en", 13'(lo_en_o), 13'(d[7:6] != 2'h0));
            chk("phase", 13'(ph_o), 13'(d[5]));
            chk("freq", 13'(freq_o), 13'(d[4:0]));
            rd(blc_pkg::OFS_LOCKOUT_PWM, d);
        end
    endtask
    task automatic t_a4();
        logic [7:0] d;
        for (int c = 0; c < 8; c++) begin
            d = {c[2:1], c[0], c[1:0], c[2:0]};
            wr(blc_pkg::OFS_RES_FAULT_HR, d);
            chk("cur_res", 13'(cur_o), 13'(d[5]));
            chk("fault", 13'(thr_o), 13'(d[4:3]));
            chk("fault_mv", flt_mv_o, 13'h08fc + 13'h03e8 * 13'(d[4:3]));
            chk("head", 13'(hr_o), 13'(d[2:0]));
            chk("head_mv", hr_mv_o, 13'h007d * 13'(c + 1));
            rd(blc_pkg::OFS_RES_FAULT_HR, d);
        end
    endtask
    // Unmapped place, then write followed at once by a read
    task automatic t_edge();
        wr(8'ha5, 8'hff);
        chk("a3_kept", 13'(freq_o), 13'h0004);
        rd(8'ha5, 8'h00);
        wr_rd(blc_pkg::OFS_LOCKOUT_PWM, 8'h20);
        rd(blc_pkg::OFS_LOCKOUT_PWM, 8'h20);
        chk("phase_only", {lvl_o, ph_o, freq_o}, 13'h0020);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #100000;
        bad_count++;
        finish_test();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        #1 t_reset();
        t_a3();
        t_a4();
        t_edge();
        @(posedge clk_i);
        reset_i <= 1'b1;
        @(posedge clk_i);
        reset_i <= 1'b0;
        #1 t_reset();
        finish_test();
    end
endmodule // test_blc_bank
